// File: lccs_top.sv
// Zero and span calibration sequencer with Avalon-MM register slave
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "lccs_cfg.svh"
module lccs_top
  import lccs_pkg::*;
(
  input  wire logic               CORE_CLK_IN,
  input  wire logic               RST_N_IN,
  input  wire logic [5:0]         AVS_ADDRESS_IN,
  input  wire logic               AVS_READ_IN,
  input  wire logic               AVS_WRITE_IN,
  input  wire logic [31:0]        AVS_WRITEDATA_IN,
  input  wire logic [3:0]         AVS_BYTEENABLE_IN,
  output logic [31:0]             AVS_READDATA_OUT,
  output logic                    AVS_WAITREQUEST_OUT,
  input  wire logic signed [23:0] ADC_DATA_IN,
  input  wire logic               ADC_VALID_IN,
  input  wire logic               STABLE_IN,
  output logic signed [31:0]      WEIGHT_OUT,
  output logic [3:0]              CAL_ERR_OUT,
  output logic                    ZERO_BUSY_OUT,
  output logic                    SPAN_BUSY_OUT
);
  lccs_top_t s;
  lccs_top_t next_s;
  lccs_div_if dv ();

  logic               avg_done;
  logic signed [23:0] avg_val;
  logic signed [24:0] diff;
  logic [24:0]        mag;
  logic signed [24:0] cal_delta;
  logic               wr_take;
  logic [31:0]        wmask;
  logic [47:0]        prod;

  // Merge write data under byte enables
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  lccs_avg u_avg (
    .clk       (CORE_CLK_IN),
    .rst_n     (RST_N_IN),
    .start_in  (s.avg_start),
    .valid_in  (ADC_VALID_IN),
    .sample_in (ADC_DATA_IN),
    .done_out  (avg_done),
    .avg_out   (avg_val)
  );

  lccs_div u_div (
    .clk   (CORE_CLK_IN),
    .rst_n (RST_N_IN),
    .dv    (dv.rsp)
  );

  // Started in the pulse's own cycle: a cycle later the converter word is gone
  assign dv.start    = next_s.div_start;
  assign dv.dividend = prod;
  assign dv.divisor  = s.span_delta;

  always_comb begin
    next_s           = s;
    next_s.div_start = 1'b0;
    next_s.avg_start = 1'b0;
    diff      = 25'(ADC_DATA_IN) - 25'(s.zero_ofs);
    mag       = diff[24] ? 25'(-diff) : diff;
    prod      = 48'(mag) * 48'(s.bal_cal);
    cal_delta = 25'(avg_val) - 25'(s.zero_ofs);
    wr_take   = AVS_WRITE_IN && !s.wait_q;
    wmask     = 32'h0;

    // One wait cycle, then the access completes on the next edge
    if ((AVS_READ_IN || AVS_WRITE_IN) && s.wait_q) begin
      next_s.wait_q = 1'b0;
      next_s.rdata  = 32'h0;
      unique case (AVS_ADDRESS_IN)
        `LCCS_OFS_CTRL:     next_s.rdata[`LCCS_BIT_LOCK] = s.lock;
        `LCCS_OFS_CMD: begin
          next_s.rdata[`LCCS_BIT_ZREQ] = s.zreq;
          next_s.rdata[`LCCS_BIT_SREQ] = s.sreq;
        end
        `LCCS_OFS_BALANCE:  next_s.rdata = 32'(s.balance);
        `LCCS_OFS_CAPACITY: next_s.rdata = 32'(s.capacity);
        `LCCS_OFS_STAT5:    next_s.rdata[`LCCS_BIT_STABLE] = STABLE_IN;
        `LCCS_OFS_STAT6: begin
          next_s.rdata[`LCCS_BIT_ZBUSY] = s.zbusy;
          next_s.rdata[`LCCS_BIT_SBUSY] = s.sbusy;
        end
        `LCCS_OFS_ERROR:    next_s.rdata = 32'(s.err);
        `LCCS_OFS_WEIGHT:   next_s.rdata = s.weight;
        `LCCS_OFS_ZERO:     next_s.rdata = 32'(signed'(s.zero_ofs));
        default:            next_s.rdata = 32'h0;
      endcase
    end else begin
      next_s.wait_q = 1'b1;
    end

    if (wr_take) begin
      unique case (AVS_ADDRESS_IN)
        `LCCS_OFS_CTRL: begin
          wmask       = lane_merge(32'(s.lock) << `LCCS_BIT_LOCK, AVS_WRITEDATA_IN,
                                   AVS_BYTEENABLE_IN);
          next_s.lock = wmask[`LCCS_BIT_LOCK];
        end
        `LCCS_OFS_CMD: begin
          wmask       = lane_merge({30'h0, s.sreq, s.zreq}, AVS_WRITEDATA_IN,
                                   AVS_BYTEENABLE_IN);
          next_s.zreq = wmask[`LCCS_BIT_ZREQ];
          next_s.sreq = wmask[`LCCS_BIT_SREQ];
        end
        `LCCS_OFS_BALANCE: begin
          wmask          = lane_merge(32'(s.balance), AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
          next_s.balance = wmask[16:0];
        end
        `LCCS_OFS_CAPACITY: begin
          wmask           = lane_merge(32'(s.capacity), AVS_WRITEDATA_IN,
                                       AVS_BYTEENABLE_IN);
          next_s.capacity = wmask[16:0];
        end
        default: begin
          wmask = 32'h0;
        end
      endcase
    end

    unique case (s.st)
      LCCS_IDLE: begin
        // Edges are sampled only here, so a request raised while busy
        // is seen once the sequencer is free again
        next_s.zreq_d = s.zreq;
        next_s.sreq_d = s.sreq;
        if (s.zreq && !s.zreq_d && !s.lock) begin
          next_s.st        = LCCS_ZERO_AVG;
          next_s.zbusy     = 1'b1;
          next_s.avg_start = 1'b1;
          if (s.err != `LCCS_ERR_SPAN_OFF) begin
            next_s.err = `LCCS_ERR_NONE;
          end
        end else if (s.sreq && !s.sreq_d && !s.lock) begin
          if (s.balance == 17'h0) begin
            next_s.err = `LCCS_ERR_BAL_ZERO;
          end else if (s.balance > s.capacity) begin
            next_s.err = `LCCS_ERR_BAL_CAP;
          end else if (!s.zero_ok || s.err == `LCCS_ERR_SPAN_OFF) begin
            // No valid zero reference: span would land far off target
            next_s.err = `LCCS_ERR_SPAN_OFF;
          end else begin
            next_s.st        = LCCS_SPAN_AVG;
            next_s.sbusy     = 1'b1;
            next_s.avg_start = 1'b1;
            next_s.err       = `LCCS_ERR_NONE;
          end
        end else if (ADC_VALID_IN) begin
          if (s.span_ok) begin
            next_s.neg       = diff[24];
            next_s.div_start = 1'b1;
            next_s.st        = LCCS_CONV;
          end else begin
            next_s.weight = 32'(diff);
          end
        end
      end
      LCCS_ZERO_AVG: begin
        if (avg_done) begin
          next_s.st    = LCCS_IDLE;
          next_s.zbusy = 1'b0;
          if (avg_val < 24'sh0) begin
            next_s.err = `LCCS_ERR_ZERO_NEG;
          end else if (25'(avg_val) > `LCCS_ZERO_MAX) begin
            next_s.err = `LCCS_ERR_ZERO_HI;
          end else begin
            next_s.zero_ofs = avg_val;
            next_s.zero_ok  = 1'b1;
            next_s.err      = `LCCS_ERR_NONE;
            next_s.weight   = 32'sh0;
          end
        end
      end
      LCCS_SPAN_AVG: begin
        if (avg_done) begin
          next_s.st    = LCCS_IDLE;
          next_s.sbusy = 1'b0;
          if (cal_delta < 25'sh0) begin
            next_s.err = `LCCS_ERR_SPAN_NEG;
          end else if (cal_delta < `LCCS_SPAN_MIN) begin
            next_s.err = `LCCS_ERR_SPAN_LO;
          end else if (cal_delta > `LCCS_SPAN_MAX) begin
            next_s.err = `LCCS_ERR_SPAN_HI;
          end else begin
            next_s.span_delta = cal_delta[23:0];
            next_s.bal_cal    = s.balance;
            next_s.span_ok    = 1'b1;
            // Scale is delta-to-balance, so the test load reads exactly
            next_s.weight     = 32'(s.balance);
          end
        end
      end
      LCCS_CONV: begin
        if (dv.done) begin
          next_s.st     = LCCS_IDLE;
          next_s.weight = s.neg ? 32'(-signed'(dv.quotient[31:0])) : dv.quotient[31:0];
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s          <= '0;
      s.wait_q   <= 1'b1;
      s.lock     <= `LCCS_RST_LOCK;
      s.balance  <= `LCCS_RST_BALANCE;
      s.capacity <= `LCCS_RST_CAPACITY;
      s.err      <= `LCCS_ERR_NONE;
      s.st       <= LCCS_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign AVS_READDATA_OUT    = s.rdata;
  assign AVS_WAITREQUEST_OUT = s.wait_q;
  assign WEIGHT_OUT          = s.weight;
  assign CAL_ERR_OUT         = s.err;
  assign ZERO_BUSY_OUT       = s.zbusy;
  assign SPAN_BUSY_OUT       = s.sbusy;
endmodule

// File: lccs_cfg.svh
// Constants for the load cell calibration sequencer
`ifndef LCCS_CFG_SVH
`define LCCS_CFG_SVH

`define LCCS_OFS_CTRL     6'h00
`define LCCS_OFS_CMD      6'h04
`define LCCS_OFS_BALANCE  6'h08
`define LCCS_OFS_CAPACITY 6'h0c
`define LCCS_OFS_STAT5    6'h10
`define LCCS_OFS_STAT6    6'h14
`define LCCS_OFS_ERROR    6'h18
`define LCCS_OFS_WEIGHT   6'h1c
`define LCCS_OFS_ZERO     6'h20

`define LCCS_BIT_LOCK     13
`define LCCS_BIT_ZREQ     0
`define LCCS_BIT_SREQ     1
`define LCCS_BIT_STABLE   10
`define LCCS_BIT_ZBUSY    4
`define LCCS_BIT_SBUSY    5

`define LCCS_RST_LOCK     1'b1
`define LCCS_RST_BALANCE  17'h00000
`define LCCS_RST_CAPACITY 17'h00000

`define LCCS_ERR_NONE     4'h0
`define LCCS_ERR_SPAN_OFF 4'h1
`define LCCS_ERR_ZERO_HI  4'h2
`define LCCS_ERR_ZERO_NEG 4'h3
`define LCCS_ERR_BAL_CAP  4'h4
`define LCCS_ERR_BAL_ZERO 4'h5
`define LCCS_ERR_SPAN_LO  4'h6
`define LCCS_ERR_SPAN_NEG 4'h7
`define LCCS_ERR_SPAN_HI  4'h8

`define LCCS_ZERO_MAX     25'sh0200000
`define LCCS_SPAN_MIN     25'sh0000400
`define LCCS_SPAN_MAX     25'sh0400000

`define LCCS_AVG_SHIFT    3
`define LCCS_AVG_LAST     3'h7
`define LCCS_DIV_LAST     6'h2f

`endif

// File: lccs_pkg.sv
// Types shared by the calibration sequencer modules
package lccs_pkg;

  typedef enum logic [2:0] {
    LCCS_IDLE,
    LCCS_ZERO_AVG,
    LCCS_SPAN_AVG,
    LCCS_CONV
  } lccs_state_t;

  typedef struct packed {
    logic              wait_q;
    logic [31:0]       rdata;
    logic              lock;
    logic              zreq;
    logic              sreq;
    logic              zreq_d;
    logic              sreq_d;
    logic [16:0]       balance;
    logic [16:0]       capacity;
    logic              zbusy;
    logic              sbusy;
    logic [3:0]        err;
    logic              zero_ok;
    logic              span_ok;
    logic signed [23:0] zero_ofs;
    logic [23:0]       span_delta;
    logic [16:0]       bal_cal;
    logic signed [31:0] weight;
    lccs_state_t       st;
    logic              div_start;
    logic              avg_start;
    logic              neg;
  } lccs_top_t;

  typedef struct packed {
    logic              busy;
    logic [2:0]        cnt;
    logic signed [26:0] sum;
    logic              done;
    logic signed [23:0] avg;
  } lccs_avg_t;

  typedef struct packed {
    logic              busy;
    logic [5:0]        cnt;
    logic [24:0]       rem;
    logic [47:0]       quo;
    logic              done;
  } lccs_div_t;

endpackage

// File: lccs_div_if.sv
// Request and answer bundle of the weight divider
`timescale 1ns/1ns
interface lccs_div_if;
  logic        start;
  logic [47:0] dividend;
  logic [23:0] divisor;
  logic        done;
  logic [47:0] quotient;

  modport req (output start, output dividend, output divisor, input done, input quotient);
  modport rsp (input start, input dividend, input divisor, output done, output quotient);
endinterface

// File: lccs_avg.sv
// Averages a fixed run of converter samples for calibration
`timescale 1ns/1ns
`include "lccs_cfg.svh"
module lccs_avg
  import lccs_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               start_in,
  input  wire logic               valid_in,
  input  wire logic signed [23:0] sample_in,
  output logic                    done_out,
  output logic signed [23:0]      avg_out
);
  lccs_avg_t s;
  lccs_avg_t next_s;
  logic signed [26:0] acc;

  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    acc         = s.sum + 27'(sample_in);
    if (start_in) begin
      next_s.busy = 1'b1;
      next_s.cnt  = 3'h0;
      next_s.sum  = 27'sh0;
    end else if (s.busy && valid_in) begin
      next_s.sum = acc;
      next_s.cnt = s.cnt + 3'h1;
      if (s.cnt == `LCCS_AVG_LAST) begin
        // Averaging rides out residual noise on the settled reading
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.avg  = 24'(acc >>> `LCCS_AVG_SHIFT);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done_out = s.done;
  assign avg_out  = s.avg;
endmodule

// File: lccs_div.sv
// Unsigned restoring divider, one quotient bit per clock
`timescale 1ns/1ns
`include "lccs_cfg.svh"
module lccs_div
  import lccs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  lccs_div_if.rsp   dv
);
  lccs_div_t s;
  lccs_div_t next_s;
  logic [24:0] trial;

  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    trial       = {s.rem[23:0], s.quo[47]};
    if (dv.start) begin
      next_s.busy = 1'b1;
      next_s.cnt  = 6'h0;
      next_s.rem  = 25'h0;
      next_s.quo  = dv.dividend;
    end else if (s.busy) begin
      if (trial >= {1'b0, dv.divisor}) begin
        next_s.rem = trial - {1'b0, dv.divisor};
        next_s.quo = {s.quo[46:0], 1'b1};
      end else begin
        next_s.rem = trial;
        next_s.quo = {s.quo[46:0], 1'b0};
      end
      next_s.cnt = s.cnt + 6'h1;
      if (s.cnt == `LCCS_DIV_LAST) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dv.done     = s.done;
  assign dv.quotient = s.quo;
endmodule

// File: lccs_cell_model.sv
// Load cell converter model feeding paced samples
`timescale 1ns/1ns
module lccs_cell_model (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic signed [23:0] level_in,
  output logic signed [23:0]      data_out,
  output logic                    valid_out,
  output logic                    stable_out
);
  logic [1:0] ph;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 2'h0;
      valid_out <= 1'b0;
      data_out <= 24'sh0;
    end else begin
      ph <= ph + 2'h1;
      valid_out <= (ph == 2'h3);
      // Inverted between pulses so a stale sample never looks fresh
      data_out <= (ph == 2'h3) ? level_in : ~data_out;
    end
  end
  // Reading held stable throughout the run
  assign stable_out = 1'b1;
endmodule

// File: lccs_top_monitor.sv
// Port checks for the calibration sequencer
`timescale 1ns/1ns
`include "lccs_cfg.svh"
module lccs_top_monitor
  import lccs_pkg::*;
(
  input wire logic               CORE_CLK_IN,
  input wire logic               RST_N_IN,
  input wire logic [5:0]         AVS_ADDRESS_IN,
  input wire logic               AVS_READ_IN,
  input wire logic               AVS_WRITE_IN,
  input wire logic [31:0]        AVS_WRITEDATA_IN,
  input wire logic [3:0]         AVS_BYTEENABLE_IN,
  input wire logic [31:0]        AVS_READDATA_OUT,
  input wire logic               AVS_WAITREQUEST_OUT,
  input wire logic signed [23:0] ADC_DATA_IN,
  input wire logic               ADC_VALID_IN,
  input wire logic               STABLE_IN,
  input wire logic signed [31:0] WEIGHT_OUT,
  input wire logic [3:0]         CAL_ERR_OUT,
  input wire logic               ZERO_BUSY_OUT,
  input wire logic               SPAN_BUSY_OUT
);
  logic [4:0]  pc;
  logic [1:0]  cmd;
  logic        lock;
  logic [16:0] bal;
  logic        land;
  logic        idle;
  // Shadows assume full byte enables, as the bench always uses
  assign land = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
  assign idle = !ZERO_BUSY_OUT && !SPAN_BUSY_OUT;
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pc <= 5'h0;
      cmd <= 2'h0;
      lock <= 1'b1;
      bal <= 17'h0;
    end else begin
      pc <= idle ? 5'h0 : pc + {4'h0, ADC_VALID_IN && pc != 5'h1f};
      if (land && AVS_ADDRESS_IN == `LCCS_OFS_CMD) cmd <= AVS_WRITEDATA_IN[1:0];
      if (land && AVS_ADDRESS_IN == `LCCS_OFS_CTRL) lock <= AVS_WRITEDATA_IN[13];
      if (land && AVS_ADDRESS_IN == `LCCS_OFS_BALANCE) bal <= AVS_WRITEDATA_IN[16:0];
    end
  end
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  a_zero_go_req: assert property (
    land && AVS_ADDRESS_IN == `LCCS_OFS_CMD && AVS_WRITEDATA_IN[0] && !cmd[0] && !lock && idle
    |-> ##[1:60] ZERO_BUSY_OUT) else $error("zero request not started");
  a_span_go_req: assert property ($rose(SPAN_BUSY_OUT) |-> cmd[1] && !ZERO_BUSY_OUT)
    else $error("span run without request");
  a_zero_run_len: assert property ($fell(ZERO_BUSY_OUT) |-> pc >= 5'h8)
    else $error("zero busy too short");
  a_span_run_len: assert property ($fell(SPAN_BUSY_OUT) |-> pc >= 5'h8)
    else $error("span busy too short");
  a_zero_res_ok: assert property (
    $fell(ZERO_BUSY_OUT) && CAL_ERR_OUT == `LCCS_ERR_NONE |-> WEIGHT_OUT == 32'sh0)
    else $error("weight not zero after zero run");
  a_zero_err_set: assert property ($fell(ZERO_BUSY_OUT) |-> CAL_ERR_OUT inside
    {`LCCS_ERR_NONE, `LCCS_ERR_SPAN_OFF, `LCCS_ERR_ZERO_HI, `LCCS_ERR_ZERO_NEG})
    else $error("bad code after zero run");
  a_span_err_set: assert property ($fell(SPAN_BUSY_OUT) |-> CAL_ERR_OUT inside
    {`LCCS_ERR_NONE, `LCCS_ERR_SPAN_LO, `LCCS_ERR_SPAN_NEG, `LCCS_ERR_SPAN_HI})
    else $error("bad code after span run");
  a_span_res_ok: assert property (
    $fell(SPAN_BUSY_OUT) && CAL_ERR_OUT == `LCCS_ERR_NONE |-> WEIGHT_OUT == {15'h0, bal})
    else $error("weight not balance after span");
  a_bal_zero_ref: assert property (
    land && AVS_ADDRESS_IN == `LCCS_OFS_CMD && AVS_WRITEDATA_IN[1:0] == 2'h2 && !cmd[1]
    && !lock && idle && bal == 17'h0 |-> ##[1:60] CAL_ERR_OUT == `LCCS_ERR_BAL_ZERO)
    else $error("zero balance span not refused");
  a_err_code_hold: assert property ($changed(CAL_ERR_OUT) |-> !idle
    || $past(ZERO_BUSY_OUT) || $past(SPAN_BUSY_OUT) || $past(AVS_WRITE_IN)
    || $past(AVS_WRITE_IN, 2)) else $error("error code moved while idle");
endmodule
bind lccs_top lccs_top_monitor u_mon (.CORE_CLK_IN, .RST_N_IN, .AVS_ADDRESS_IN, .AVS_READ_IN,
  .AVS_WRITE_IN, .AVS_WRITEDATA_IN, .AVS_BYTEENABLE_IN, .AVS_READDATA_OUT,
  .AVS_WAITREQUEST_OUT, .ADC_DATA_IN, .ADC_VALID_IN, .STABLE_IN, .WEIGHT_OUT,
  .CAL_ERR_OUT, .ZERO_BUSY_OUT, .SPAN_BUSY_OUT);

// File: lccs_top_tb.sv
// Register level testbench for the calibration sequencer
`timescale 1ns/1ns
`include "lccs_cfg.svh"
module lccs_top_tb
  import lccs_pkg::*;
;
  logic               clk;
  logic               rst_n = 1'b0;
  logic               rd = 1'b0;
  logic               wr = 1'b0;
  logic [5:0]         addr = 6'h0;
  logic [31:0]        wdata = 32'h0;
  logic [31:0]        rdata;
  logic               wq;
  logic signed [23:0] adc;
  logic signed [23:0] level = 24'sh0;
  logic               vld;
  logic               stab;
  logic               zb;
  logic               sb;
  logic signed [31:0] wt;
  logic [3:0]         err;
  int                 num_errors = 0;
  int                 n_compared = 0;
  int                 cyc = 0;
  lccs_top dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wq),
    .ADC_DATA_IN(adc), .ADC_VALID_IN(vld), .STABLE_IN(stab), .WEIGHT_OUT(wt),
    .CAL_ERR_OUT(err), .ZERO_BUSY_OUT(zb), .SPAN_BUSY_OUT(sb));
  lccs_cell_model u_cell (.clk(clk), .rst_n(rst_n), .level_in(level), .data_out(adc),
    .valid_out(vld), .stable_out(stab));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("mismatches %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // Whole run needs under a thousand cycles
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 20);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 20) chk(32'h1, 32'h0);
    // One idle edge so release and next request never share a step
    @(posedge clk);
  endtask
  task automatic wrr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic cal(input int b, input logic signed [23:0] s, input logic [3:0] e,
                     input logic busy);
    int n;
    n = 0;
    level <= s;
    wrr(`LCCS_OFS_CMD, 32'h1 << b);
    rdchk(`LCCS_OFS_STAT6, busy ? 32'h10 << b : 32'h0);
    while ((zb | sb) !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    // A run that never ends shows up here rather than as a silent wait
    chk({30'h0, zb, sb}, 32'h0);
    rdchk(`LCCS_OFS_ERROR, {28'h0, e});
    chk({28'h0, err}, {28'h0, e});
    wrr(`LCCS_OFS_CMD, 32'h0);
    $display("test cal bit %0d code %0d done", b, e);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(`LCCS_OFS_CTRL, 32'h2000);
    rdchk(`LCCS_OFS_BALANCE, 32'h0);
    rdchk(`LCCS_OFS_WEIGHT, 32'h0);
    wrr(6'h3c, 32'hffffffff);
    rdchk(6'h3c, 32'h0);
    $display("test reset done");
    cal(0, 24'sd1000, `LCCS_ERR_NONE, 1'b0);
    wrr(`LCCS_OFS_CTRL, 32'h0);
    rdchk(`LCCS_OFS_STAT5, 32'h400);
    wrr(`LCCS_OFS_BALANCE, 32'd100);
    wrr(`LCCS_OFS_CAPACITY, 32'd200);
    cal(1, 24'sd1000, `LCCS_ERR_SPAN_OFF, 1'b0);
    cal(0, 24'sd1000, `LCCS_ERR_NONE, 1'b1);
    cal(0, -24'sd5, `LCCS_ERR_ZERO_NEG, 1'b1);
    cal(0, 24'sh300000, `LCCS_ERR_ZERO_HI, 1'b1);
    cal(0, 24'sd1000, `LCCS_ERR_NONE, 1'b1);
    rdchk(`LCCS_OFS_WEIGHT, 32'h0);
    rdchk(`LCCS_OFS_ZERO, 32'd1000);
    wrr(`LCCS_OFS_BALANCE, 32'd0);
    cal(1, 24'sd1000, `LCCS_ERR_BAL_ZERO, 1'b0);
    rdchk(`LCCS_OFS_ERROR, 32'h5);
    wrr(`LCCS_OFS_BALANCE, 32'd300);
    cal(1, 24'sd1000, `LCCS_ERR_BAL_CAP, 1'b0);
    wrr(`LCCS_OFS_BALANCE, 32'd100);
    cal(1, 24'sd995, `LCCS_ERR_SPAN_NEG, 1'b1);
    cal(1, 24'sd1256, `LCCS_ERR_SPAN_LO, 1'b1);
    cal(1, 24'sh5003e8, `LCCS_ERR_SPAN_HI, 1'b1);
    cal(1, 24'sh0013e8, `LCCS_ERR_NONE, 1'b1);
    rdchk(`LCCS_OFS_WEIGHT, 32'd100);
    level <= 24'sh000be8;
    repeat (200) @(posedge clk);
    rdchk(`LCCS_OFS_WEIGHT, 32'd50);
    chk(wt, 32'd50);
    $display("test weight scale done");
    report_and_stop;
  end
endmodule
